// ### core/qdsi_dac_input.sv
/*
 * Serial command input and channel latches of a four-channel 8-bit DAC.
 * Assumes all serial pins are asynchronous to clk_sys and the serial
 * clock is much slower than clk_sys (at least four clk_sys per phase).
 */
`timescale 1ns/1ps
`include "qdsi_defines.svh"

module qdsi_dac_input
	import qdsi_pkg::*;
#(
	parameter int FIFO_DEPTH = 2
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic chipSelN,
	input wire logic frameSync,
	input wire logic serialClk,
	input wire logic serialData,
	input wire logic hwPowerdownN,
	input wire logic applyHold,
	output logic [`QDSI_CHANNELS-1:0][`QDSI_CODE_W-1:0] dacCode_q,
	output logic powerDown_q,
	output logic fastSettle_q,
	output logic ampEnable_q,
	output logic updateStrobe_q,
	output logic [1:0] updateChan_q,
	output logic overrun_q
);

	// Synchronised pins
	logic [`QDSI_SYNC_W-1:0] pinSync;
	logic csNSync;
	logic fsSync;
	logic sclkSync;
	logic sdatSync;
	logic pdNSync;

	qdsi_sync #(
		.WIDTH(`QDSI_SYNC_W),
		.RST_VAL(`QDSI_SYNC_RST)
	) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.async_i({hwPowerdownN, chipSelN, frameSync, serialClk, serialData}),
		.sync_q(pinSync)
	);

	always_comb begin
		pdNSync = pinSync[`QDSI_IX_PDN];
		csNSync = pinSync[`QDSI_IX_CSN];
		fsSync = pinSync[`QDSI_IX_FS];
		sclkSync = pinSync[`QDSI_IX_SCLK];
		sdatSync = pinSync[`QDSI_IX_SDAT];
	end

	// Edge detection on the synchronised pins
	logic sclkPrev_q, sclkPrev_d;
	logic fsPrev_q, fsPrev_d;
	logic sclkFall, sclkRise;
	logic fsFall, fsRise;

	always_comb begin
		sclkPrev_d = sclkSync;
		fsPrev_d = fsSync;
		sclkFall = sclkPrev_q && !sclkSync;
		sclkRise = !sclkPrev_q && sclkSync;
		fsFall = fsPrev_q && !fsSync;
		fsRise = !fsPrev_q && fsSync;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			// Idle level of the serial clock and frame sync pins, so no false edge after reset
			sclkPrev_q <= 1'b1;
			fsPrev_q <= 1'b1;
		end else begin
			sclkPrev_q <= sclkPrev_d;
			fsPrev_q <= fsPrev_d;
		end
	end

	// Frame receiver
	qdsi_state_t state_q, state_d;
	logic [`QDSI_WORD_BITS-1:0] shift_q, shift_d;
	logic [`QDSI_CNT_W-1:0] bitCnt_q, bitCnt_d;
	logic [`QDSI_WORD_BITS-1:0] pendWord_q, pendWord_d;
	logic pendValid_q, pendValid_d;
	logic overrun_d;
	logic emit;
	logic fifoInReady;

	always_comb begin
		state_d = state_q;
		shift_d = shift_q;
		bitCnt_d = bitCnt_q;
		emit = 1'b0;
		if (csNSync) begin
			// Deselected: no serial pin activity reaches shift register or latches
			state_d = QDSI_IDLE;
		end else begin
			case (state_q)
				QDSI_IDLE: begin
					if (fsFall) begin
						state_d = QDSI_SHIFT;
						bitCnt_d = `QDSI_CNT_ZERO;
					end
				end
				QDSI_SHIFT: begin
					if (fsRise && bitCnt_q != `QDSI_CNT_ZERO) begin
						emit = 1'b1;
						state_d = QDSI_IDLE;
					end else if (fsRise) begin
						state_d = QDSI_IDLE;
					end else if (sclkFall) begin
						shift_d = {shift_q[`QDSI_WORD_BITS-2:0], sdatSync};
						bitCnt_d = bitCnt_q + `QDSI_CNT_ONE;
						if (bitCnt_q + `QDSI_CNT_ONE == `QDSI_CNT_FULL) begin
							state_d = QDSI_WAIT_RISE;
						end
					end
				end
				QDSI_WAIT_RISE: begin
					if (sclkRise || fsRise) begin
						emit = 1'b1;
						state_d = QDSI_IDLE;
					end
				end
				default: begin
					state_d = QDSI_IDLE;
				end
			endcase
		end
	end

	// Word waiting for room in the buffer
	always_comb begin
		pendWord_d = pendWord_q;
		pendValid_d = pendValid_q;
		overrun_d = overrun_q;
		if (pendValid_q && fifoInReady) begin
			pendValid_d = 1'b0;
		end
		if (emit) begin
			if (pendValid_q && !fifoInReady) begin
				// Buffer and holding stage full: newest word is dropped
				overrun_d = 1'b1;
			end else begin
				pendWord_d = shift_d;
				pendValid_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= QDSI_IDLE;
			shift_q <= `QDSI_WORD_RST;
			bitCnt_q <= `QDSI_CNT_ZERO;
			pendWord_q <= `QDSI_WORD_RST;
			pendValid_q <= 1'b0;
			overrun_q <= 1'b0;
		end else begin
			state_q <= state_d;
			shift_q <= shift_d;
			bitCnt_q <= bitCnt_d;
			pendWord_q <= pendWord_d;
			pendValid_q <= pendValid_d;
			overrun_q <= overrun_d;
		end
	end

	// Buffer between receiver and latch stage
	logic fifoOutValid;
	logic fifoOutReady;
	logic [`QDSI_WORD_BITS-1:0] fifoOutData;

	qdsi_fifo #(
		.WIDTH(`QDSI_WORD_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.inValid(pendValid_q),
		.inReady(fifoInReady),
		.inData(pendWord_q),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.outData(fifoOutData)
	);

	// Latch stage: decode word, update addressed channel and controls
	logic [1:0] wordChan;
	logic wordPwr;
	logic wordSpd;
	logic [`QDSI_CODE_W-1:0] wordCode;
	logic apply;
	logic powerDown_d;
	logic fastSettle_d;
	logic ampEnable_d;
	logic updateStrobe_d;
	logic [1:0] updateChan_d;

	always_comb begin
		fifoOutReady = !applyHold;
		apply = fifoOutValid && !applyHold;
		wordChan = fifoOutData[`QDSI_ADDR_HI:`QDSI_ADDR_LO];
		wordPwr = fifoOutData[`QDSI_PWR_BIT];
		wordSpd = fifoOutData[`QDSI_SPD_BIT];
		wordCode = fifoOutData[`QDSI_CODE_HI:`QDSI_CODE_LO];
		powerDown_d = apply ? wordPwr : powerDown_q;
		fastSettle_d = apply ? wordSpd : fastSettle_q;
		ampEnable_d = !powerDown_d && pdNSync;
		updateStrobe_d = apply;
		updateChan_d = apply ? wordChan : updateChan_q;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			powerDown_q <= 1'b0;
			fastSettle_q <= 1'b0;
			ampEnable_q <= 1'b0;
			updateStrobe_q <= 1'b0;
			updateChan_q <= QDSI_CHAN_A;
		end else begin
			powerDown_q <= powerDown_d;
			fastSettle_q <= fastSettle_d;
			ampEnable_q <= ampEnable_d;
			updateStrobe_q <= updateStrobe_d;
			updateChan_q <= updateChan_d;
		end
	end

	// One code latch per channel
	genvar ch;
	generate
		for (ch = 0; ch < `QDSI_CHANNELS; ch++) begin : g_chan
			logic [`QDSI_CODE_W-1:0] code_d;
			always_comb begin
				code_d = dacCode_q[ch];
				if (apply && wordChan == 2'(ch)) begin
					code_d = wordCode;
				end
			end
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					dacCode_q[ch] <= `QDSI_CODE_RST;
				end else begin
					dacCode_q[ch] <= code_d;
				end
			end
		end
	endgenerate

endmodule : qdsi_dac_input

// ### core/qdsi_defines.svh
/*
 * Bit positions, widths and reset values of the quad DAC serial input.
 * Assumes inclusion by bare name from the core/ directory.
 */
`ifndef QDSI_DEFINES_SVH
`define QDSI_DEFINES_SVH

`define QDSI_WORD_BITS 16
`define QDSI_CNT_W 5
`define QDSI_CNT_FULL 5'h10
`define QDSI_CNT_ZERO 5'h00
`define QDSI_CNT_ONE 5'h01
`define QDSI_ADDR_HI 15
`define QDSI_ADDR_LO 14
`define QDSI_PWR_BIT 13
`define QDSI_SPD_BIT 12
`define QDSI_CODE_HI 11
`define QDSI_CODE_LO 4
`define QDSI_CODE_W 8
`define QDSI_CHANNELS 4
`define QDSI_WORD_RST 16'h0000
`define QDSI_CODE_RST 8'h00

`define QDSI_SYNC_W 5
`define QDSI_SYNC_RST 5'b1_1110
`define QDSI_IX_PDN 4
`define QDSI_IX_CSN 3
`define QDSI_IX_FS 2
`define QDSI_IX_SCLK 1
`define QDSI_IX_SDAT 0

`endif

// ### core/qdsi_fifo.sv
/*
 * Small valid/ready FIFO holding received command words.
 * Assumes both sides run on clk_sys; DEPTH is a power of two.
 */
`timescale 1ns/1ps

module qdsi_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [PW:0] count_q, count_d;
	logic push, pop;

	always_comb begin
		inReady = (count_q != PW'(0) + (PW+1)'(DEPTH));
		outValid = (count_q != '0);
		outData = mem_q[rdPtr_q];
		push = inValid && inReady;
		pop = outValid && outReady;
		wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
		rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
		count_d = count_q + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
			for (int k = 0; k < DEPTH; k++) begin
				mem_q[k] <= '0;
			end
		end else begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
			if (push) begin
				mem_q[wrPtr_q] <= inData;
			end
		end
	end

endmodule : qdsi_fifo

// ### core/qdsi_pkg.sv
/*
 * Types shared by the quad DAC serial input block.
 * Assumes nothing of its surroundings.
 */
package qdsi_pkg;

	typedef enum logic [1:0] {
		QDSI_IDLE,
		QDSI_SHIFT,
		QDSI_WAIT_RISE
	} qdsi_state_t;

	typedef enum logic [1:0] {
		QDSI_CHAN_A,
		QDSI_CHAN_B,
		QDSI_CHAN_C,
		QDSI_CHAN_D
	} qdsi_chan_t;

endpackage : qdsi_pkg

// ### core/qdsi_sync.sv
/*
 * Two-flop synchroniser for a group of level inputs.
 * Assumes inputs come from pins outside the clk_sys domain.
 */
`timescale 1ns/1ps

module qdsi_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_q
);

	logic [WIDTH-1:0] meta_q;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					meta_q[i] <= RST_VAL[i];
					sync_q[i] <= RST_VAL[i];
				end else begin
					meta_q[i] <= async_i[i];
					sync_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate

endmodule : qdsi_sync

// ### dv/qdsi_dac_input_sva.sv
/*
 * Checker for the quad DAC serial input, bound to its top module.
 * Assumes the bench drives rst high at start and clk_sys throughout.
 */
`timescale 1ns/1ps
`include "qdsi_defines.svh"

module qdsi_dac_input_sva
	import qdsi_pkg::*;
#(
	parameter int FIFO_DEPTH = 2
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic chipSelN,
	input wire logic frameSync,
	input wire logic serialClk,
	input wire logic serialData,
	input wire logic hwPowerdownN,
	input wire logic applyHold,
	input wire logic [`QDSI_CHANNELS-1:0][`QDSI_CODE_W-1:0] dacCode_q,
	input wire logic powerDown_q,
	input wire logic fastSettle_q,
	input wire logic ampEnable_q,
	input wire logic updateStrobe_q,
	input wire logic [1:0] updateChan_q,
	input wire logic overrun_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [4:0] idleCnt_q;
	logic [4:0] idleCnt_d;
	// Cycles with chip select high and nothing held back
	always_comb begin
		idleCnt_d = idleCnt_q;
		if (!chipSelN || applyHold) idleCnt_d = 5'h00;
		else if (idleCnt_q != 5'h1F) idleCnt_d = idleCnt_q + 5'h01;
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) idleCnt_q <= 5'h00;
		else idleCnt_q <= idleCnt_d;
	end
	sequence s_hwLow;
		!hwPowerdownN [*5];
	endsequence
	sequence s_hwOn;
		(hwPowerdownN && !powerDown_q) [*5];
	endsequence
	property p_resetClear;
		$fell(rst) |-> dacCode_q == '0 && !powerDown_q && !fastSettle_q;
	endproperty
	property p_codeByStrobe;
		$changed(dacCode_q) |-> updateStrobe_q;
	endproperty
	property p_chanByStrobe;
		$changed(updateChan_q) |-> updateStrobe_q;
	endproperty
	property p_ctlByStrobe;
		$changed({powerDown_q, fastSettle_q}) |-> updateStrobe_q;
	endproperty
	property p_idleQuiet;
		idleCnt_q >= 5'h14 |-> !updateStrobe_q;
	endproperty
	property p_ampOff;
		ampEnable_q |-> !powerDown_q;
	endproperty
	property p_hwOff;
		s_hwLow |-> !ampEnable_q;
	endproperty
	property p_hwOn;
		s_hwOn |-> ampEnable_q;
	endproperty
	a_resetClear: assert property (p_resetClear) else $error("not clear after reset");
	a_codeByStrobe: assert property (p_codeByStrobe) else $error("code moved alone");
	a_chanByStrobe: assert property (p_chanByStrobe) else $error("channel moved alone");
	a_ctlByStrobe: assert property (p_ctlByStrobe) else $error("control moved alone");
	a_idleQuiet: assert property (p_idleQuiet) else $error("update while deselected");
	a_ampOff: assert property (p_ampOff) else $error("amp on in power-down");
	a_hwOff: assert property (p_hwOff) else $error("amp on with pin low");
	a_hwOn: assert property (p_hwOn) else $error("amp off with pin high");
endmodule : qdsi_dac_input_sva

bind qdsi_dac_input qdsi_dac_input_sva #(.FIFO_DEPTH(FIFO_DEPTH)) i_sva (.*);

// ### dv/qdsi_host_model.sv
/*
 * Host serial port model driving the four link pins.
 * Assumes calls from one process; serial clock period 64 ns at 125 MHz.
 */
`timescale 1ns/1ps

module qdsi_host_model (
	input wire logic clk_sys,
	output logic chipSelN,
	output logic frameSync,
	output logic serialClk,
	output logic serialData
);
	initial begin
		chipSelN = 1'b1;
		frameSync = 1'b1;
		serialClk = 1'b1;
		serialData = 1'b0;
	end
	task automatic waitClk(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : waitClk
	// Short word with chip select on aborts the frame
	task automatic sendWord(input logic [15:0] w, input int n, input bit fsEnd, input bit csOn);
		chipSelN = !csOn;
		waitClk(4);
		frameSync = 1'b0;
		waitClk(4);
		for (int i = 15; i > 15 - n; i--) begin
			serialData = w[i];
			waitClk(4);
			serialClk = 1'b0;
			waitClk(4);
			if (i == 0 && fsEnd) begin
				frameSync = 1'b1;
				waitClk(4);
			end
			serialClk = 1'b1;
		end
		serialData = !serialData;
		waitClk(4);
		if (n < 16) chipSelN = 1'b1;
		frameSync = 1'b1;
		waitClk(4);
		chipSelN = 1'b1;
		waitClk(8);
	endtask : sendWord
endmodule : qdsi_host_model

// ### dv/tb_quad_dac_serial_input.sv
/*
 * Self-checking bench for the quad DAC serial input.
 * Assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`include "qdsi_defines.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end

module tb_quad_dac_serial_input;
	import qdsi_pkg::*;
	logic clk_sys, rst, chipSelN, frameSync, serialClk, serialData, hwPowerdownN, applyHold;
	logic [`QDSI_CHANNELS-1:0][`QDSI_CODE_W-1:0] dacCode_q;
	logic powerDown_q, fastSettle_q, ampEnable_q, updateStrobe_q, overrun_q;
	logic [1:0] updateChan_q;
	logic [15:0] expQ[$];
	logic [15:0] w;
	logic [31:0] r;
	int fails, num_checks, seed;

	qdsi_dac_input i_dut (.*);
	qdsi_host_model i_host (.*);

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : give_verdict
	task automatic send(input logic [15:0] v, input int n, input bit fsEnd, input bit cs, input bit keep);
		if (keep) expQ.push_back(v);
		i_host.sendWord(v, n, fsEnd, cs);
	endtask : send
	task automatic drain();
		for (int k = 0; k < 200 && expQ.size() > 0; k++) @(posedge clk_sys);
		if (expQ.size() > 0) begin
			fails++;
			give_verdict();
		end
		#1;
	endtask : drain
	// Each applied word is matched against the oldest note
	always @(posedge clk_sys) begin
		if (updateStrobe_q === 1'b1) begin
			if (expQ.size() == 0) `CHK(updateStrobe_q, 1'b0)
			else begin
				w = expQ.pop_front();
				`CHK({updateChan_q, powerDown_q, fastSettle_q, dacCode_q[w[15:14]]}, w[15:4])
			end
		end
	end
	initial begin
		seed = 57;
		rst = 1'b1;
		hwPowerdownN = 1'b1;
		applyHold = 1'b0;
		repeat (8) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		`CHK({dacCode_q, powerDown_q, fastSettle_q}, 34'h0_0000_0000)
		for (int c = 0; c < 4; c++) begin
			r = $random(seed);
			send({c[1:0], r[1:0], r[11:4], 4'h0}, 16, 1'b0, 1'b1, 1'b1);
		end
		send(16'h3FF0, 16, 1'b0, 1'b1, 1'b1);
		send(16'hC000, 16, 1'b0, 1'b1, 1'b1);
		// Last applied word keeps power on, so the pin alone decides below
		send(16'h4A50, 16, 1'b1, 1'b1, 1'b1);
		send(16'hFFF0, 16, 1'b0, 1'b0, 1'b0);
		send(16'hBFF0, 8, 1'b0, 1'b1, 1'b0);
		drain();
		hwPowerdownN = 1'b0;
		i_host.waitClk(6);
		`CHK(ampEnable_q, 1'b0)
		hwPowerdownN = 1'b1;
		i_host.waitClk(6);
		`CHK(ampEnable_q, 1'b1)
		`CHK(dacCode_q[1], 8'hA5)
		applyHold = 1'b1;
		for (int c = 0; c < 4; c++) begin
			r = $random(seed);
			if (c == 3) `CHK(overrun_q, 1'b0)
			send(r[15:0] & 16'hFFF0, 16, 1'b0, 1'b1, c < 3);
		end
		`CHK(overrun_q, 1'b1)
		applyHold = 1'b0;
		drain();
		give_verdict();
	end
endmodule : tb_quad_dac_serial_input
